// *** inc/skc_params.svh ***
`ifndef SKC_PARAMS_SVH
`define SKC_PARAMS_SVH

// frame bytes
`define SKC_CLA           8'h80
`define SKC_INS_LOAD      8'hD8
`define SKC_INS_KEY       8'h52
`define SKC_INS_CARD      8'hA4
`define SKC_INS_PAGE      8'hA6
`define SKC_P1_ZERO       8'h00
`define SKC_P1_CREDIT     8'h10
`define SKC_P1_DEBIT      8'h30
`define SKC_LEN_LOAD      8'h0C
`define SKC_LEN_KEY       8'h08
`define SKC_LEN_CARD      8'h09
`define SKC_LEN_PAGE      8'h08
`define SKC_HDR_LAST      3'h4
`define SKC_BUF_BYTES     12
`define SKC_RSP_BYTES     11

// key numbers
`define SKC_KEY_XFER      5'h00
`define SKC_KEY_MAX       8'h10
`define SKC_KEY_COUNT     17
`define SKC_KEY_RST       64'h0000_0000_0000_0000

// status words
`define SKC_SW_OK         16'h9000
`define SKC_SW_BADKEY     16'h6A82
`define SKC_SW_BADP1      16'h6A86
`define SKC_SW_BADLEN     16'h6700
`define SKC_SW_BADINS     16'h6D00
`define SKC_SW_BADCLA     16'h6E00
`define SKC_SW_AUTHFAIL   16'h6300

// mixing rotation
`define SKC_MIX_ROT       5

`endif

// *** inc/skc_pkg.sv ***
package skc_pkg;

  typedef enum logic [2:0] {
    ST_HDR,
    ST_DATA,
    ST_EXEC,
    ST_CARD,
    ST_RESP,
    ST_VERD,
    ST_REPLY
  } skc_state_e;

endpackage

// *** src/skc_cmd_handler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "skc_params.svh"

module skc_cmd_handler
  import skc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  // host byte stream in
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_VALID_I,
  output logic             RX_READY_O,
  // host byte stream out
  output logic [7:0]       TX_DATA_O,
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  // card exchange
  output logic             CARD_START_O,
  input  wire logic        CARD_READY_I,
  input  wire logic [63:0] CARD_SERIAL_I,
  input  wire logic [31:0] CARD_CHAL_I,
  input  wire logic [63:0] CARD_CFG_I,
  output logic [31:0]      COUPLER_RESP_O,
  output logic             COUPLER_RESP_VALID_O,
  input  wire logic        CARD_VERDICT_I,
  input  wire logic        CARD_ACCEPT_I,
  input  wire logic [31:0] CARD_RESULT_I,
  // authentication state
  output logic             AUTH_OK_O,
  // write signature
  input  wire logic [31:0] WR_DATA_I,
  input  wire logic        WR_VALID_I,
  output logic [31:0]      SIG_O,
  output logic             SIG_VALID_O
);

  skc_state_e  state_ff;
  logic [7:0]  hdr_ff [0:4];
  logic [2:0]  hcnt_ff;
  logic [7:0]  dcnt_ff;
  logic [7:0]  buf_ff [0:`SKC_BUF_BYTES-1];
  logic [63:0] key_ff [0:`SKC_KEY_COUNT-1];
  logic [4:0]  cur_ff;
  logic [4:0]  auth_key_ff;
  logic [63:0] serial_ff;
  logic [63:0] div_ff;
  logic [31:0] chal_ff;
  logic [63:0] cfg_ff;
  logic [7:0]  rsp_ff [0:`SKC_RSP_BYTES-1];
  logic [3:0]  rsp_len_ff;
  logic [3:0]  rsp_idx_ff;
  logic        auth_ok_ff;
  logic        start_ff;
  logic        resp_valid_ff;
  logic [31:0] resp_ff;
  logic        sig_valid_ff;
  logic [31:0] sig_ff;

  logic [63:0] buf64;
  logic [63:0] plain_w;
  logic [63:0] div_w;
  logic [63:0] resp_w;
  logic [63:0] cres_w;
  logic [63:0] sig_w;
  logic [4:0]  div_sel;
  logic [63:0] div_ser;
  logic [4:0]  slot2;
  logic        key_bad;
  logic        load_go;

  assign buf64 = {buf_ff[0], buf_ff[1], buf_ff[2], buf_ff[3],
                  buf_ff[4], buf_ff[5], buf_ff[6], buf_ff[7]};
  assign key_bad = (hdr_ff[3] > `SKC_KEY_MAX);
  // even offset of the debit/credit pair holding the current key
  assign slot2 = (cur_ff == `SKC_KEY_XFER) ? 5'h00
               : ((cur_ff - 5'h01) & 5'h1E);

  // diversification source: card serial during select, else host data
  always_comb begin
    if (state_ff == ST_CARD) begin
      div_sel = auth_key_ff;
      div_ser = CARD_SERIAL_I;
    end else begin
      div_sel = hdr_ff[3][4:0];
      div_ser = buf64;
    end
  end

  skc_key_mix #(.W(64)) u_decipher (
    .a_i (buf64),
    .b_i (key_ff[`SKC_KEY_XFER]),
    .y_o (plain_w)
  );

  skc_key_mix #(.W(64)) u_diversify (
    .a_i (key_ff[div_sel]),
    .b_i (div_ser),
    .y_o (div_w)
  );

  skc_key_mix #(.W(64)) u_coupler_res (
    .a_i (div_ff),
    .b_i ({chal_ff, chal_ff}),
    .y_o (resp_w)
  );

  skc_key_mix #(.W(64)) u_card_res (
    .a_i (div_ff),
    .b_i ({~chal_ff, chal_ff}),
    .y_o (cres_w)
  );

  skc_key_mix #(.W(64)) u_signature (
    .a_i (div_ff),
    .b_i ({WR_DATA_I, WR_DATA_I}),
    .y_o (sig_w)
  );

  assign load_go = (state_ff == ST_EXEC) && (hdr_ff[0] == `SKC_CLA)
                && (hdr_ff[1] == `SKC_INS_LOAD)
                && (hdr_ff[2] == `SKC_P1_ZERO)
                && (hdr_ff[4] == `SKC_LEN_LOAD) && !key_bad;

  // key store, written only with deciphered values
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < `SKC_KEY_COUNT; i++) begin
        key_ff[i] <= `SKC_KEY_RST;
      end
    end else if (load_go) begin
      key_ff[hdr_ff[3][4:0]] <= plain_w;
    end
  end

  // signature appended to outgoing write data
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sig_ff       <= 32'h0000_0000;
      sig_valid_ff <= 1'b0;
    end else begin
      sig_valid_ff <= WR_VALID_I;
      if (WR_VALID_I) begin
        sig_ff <= sig_w[31:0];
      end
    end
  end

  // command sequencer
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff      <= ST_HDR;
      hcnt_ff       <= 3'h0;
      dcnt_ff       <= 8'h00;
      cur_ff        <= `SKC_KEY_XFER;
      auth_key_ff   <= `SKC_KEY_XFER;
      serial_ff     <= 64'h0000_0000_0000_0000;
      div_ff        <= 64'h0000_0000_0000_0000;
      chal_ff       <= 32'h0000_0000;
      cfg_ff        <= 64'h0000_0000_0000_0000;
      rsp_len_ff    <= 4'h0;
      rsp_idx_ff    <= 4'h0;
      auth_ok_ff    <= 1'b0;
      start_ff      <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_ff       <= 32'h0000_0000;
      for (int i = 0; i < 5; i++) begin
        hdr_ff[i] <= 8'h00;
      end
      for (int i = 0; i < `SKC_BUF_BYTES; i++) begin
        buf_ff[i] <= 8'h00;
      end
      for (int i = 0; i < `SKC_RSP_BYTES; i++) begin
        rsp_ff[i] <= 8'h00;
      end
    end else begin
      start_ff      <= 1'b0;
      resp_valid_ff <= 1'b0;
      unique case (state_ff)
        ST_HDR: begin
          if (RX_VALID_I) begin
            hdr_ff[hcnt_ff] <= RX_DATA_I;
            if (hcnt_ff == `SKC_HDR_LAST) begin
              hcnt_ff  <= 3'h0;
              dcnt_ff  <= 8'h00;
              state_ff <= (RX_DATA_I == 8'h00) ? ST_EXEC : ST_DATA;
            end else begin
              hcnt_ff <= hcnt_ff + 3'h1;
            end
          end
        end
        ST_DATA: begin
          if (RX_VALID_I) begin
            if (dcnt_ff < 8'(`SKC_BUF_BYTES)) begin
              buf_ff[dcnt_ff[3:0]] <= RX_DATA_I;
            end
            dcnt_ff <= dcnt_ff + 8'h01;
            if (dcnt_ff + 8'h01 == hdr_ff[4]) begin
              state_ff <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          rsp_ff[0]  <= hdr_ff[1];
          rsp_ff[1]  <= 8'(`SKC_SW_OK >> 8);
          rsp_ff[2]  <= 8'(`SKC_SW_OK);
          rsp_len_ff <= 4'h3;
          rsp_idx_ff <= 4'h0;
          state_ff   <= ST_REPLY;
          if (hdr_ff[0] != `SKC_CLA) begin
            rsp_ff[0]  <= 8'(`SKC_SW_BADCLA >> 8);
            rsp_ff[1]  <= 8'(`SKC_SW_BADCLA);
            rsp_len_ff <= 4'h2;
          end else begin
            unique case (hdr_ff[1])
              `SKC_INS_LOAD, `SKC_INS_KEY: begin
                if (key_bad) begin
                  rsp_ff[0]  <= 8'(`SKC_SW_BADKEY >> 8);
                  rsp_ff[1]  <= 8'(`SKC_SW_BADKEY);
                  rsp_len_ff <= 4'h2;
                end else if (hdr_ff[4] != ((hdr_ff[1] == `SKC_INS_LOAD)
                             ? `SKC_LEN_LOAD : `SKC_LEN_KEY)) begin
                  rsp_ff[0]  <= 8'(`SKC_SW_BADLEN >> 8);
                  rsp_ff[1]  <= 8'(`SKC_SW_BADLEN);
                  rsp_len_ff <= 4'h2;
                end else if (hdr_ff[1] == `SKC_INS_KEY) begin
                  cur_ff <= hdr_ff[3][4:0];
                  if (buf64 != 64'h0000_0000_0000_0000) begin
                    div_ff     <= div_w;
                    serial_ff  <= buf64;
                    auth_ok_ff <= 1'b0;
                  end
                end
              end
              `SKC_INS_CARD, `SKC_INS_PAGE: begin
                if (hdr_ff[4] != ((hdr_ff[1] == `SKC_INS_CARD)
                    ? `SKC_LEN_CARD : `SKC_LEN_PAGE)) begin
                  rsp_ff[0]  <= 8'(`SKC_SW_BADLEN >> 8);
                  rsp_ff[1]  <= 8'(`SKC_SW_BADLEN);
                  rsp_len_ff <= 4'h2;
                end else if (hdr_ff[1] == `SKC_INS_CARD
                             && hdr_ff[2] != `SKC_P1_CREDIT
                             && hdr_ff[2] != `SKC_P1_DEBIT) begin
                  rsp_ff[0]  <= 8'(`SKC_SW_BADP1 >> 8);
                  rsp_ff[1]  <= 8'(`SKC_SW_BADP1);
                  rsp_len_ff <= 4'h2;
                end else begin
                  // credit on 10h, debit on 30h
                  auth_key_ff <= (hdr_ff[2] == `SKC_P1_CREDIT)
                               ? slot2 + 5'h02 : slot2 + 5'h01;
                  auth_ok_ff  <= 1'b0;
                  start_ff    <= 1'b1;
                  state_ff    <= ST_CARD;
                end
              end
              default: begin
                rsp_ff[0]  <= 8'(`SKC_SW_BADINS >> 8);
                rsp_ff[1]  <= 8'(`SKC_SW_BADINS);
                rsp_len_ff <= 4'h2;
              end
            endcase
          end
        end
        ST_CARD: begin
          if (CARD_READY_I) begin
            chal_ff  <= CARD_CHAL_I;
            cfg_ff   <= CARD_CFG_I;
            state_ff <= ST_RESP;
            if (hdr_ff[1] == `SKC_INS_CARD) begin
              serial_ff <= CARD_SERIAL_I;
              div_ff    <= div_w;
            end
          end
        end
        ST_RESP: begin
          resp_ff       <= resp_w[31:0];
          resp_valid_ff <= 1'b1;
          state_ff      <= ST_VERD;
        end
        ST_VERD: begin
          if (CARD_VERDICT_I) begin
            rsp_idx_ff <= 4'h0;
            state_ff   <= ST_REPLY;
            // card acceptance and the card's own result checked together in the verdict cycle
            if (CARD_ACCEPT_I && CARD_RESULT_I == cres_w[31:0]) begin
              auth_ok_ff <= 1'b1;
              rsp_ff[0]  <= hdr_ff[1];
              for (int i = 0; i < 8; i++) begin
                rsp_ff[i+1] <= (hdr_ff[1] == `SKC_INS_PAGE)
                             ? cfg_ff[63-8*i -: 8]
                             : serial_ff[63-8*i -: 8];
              end
              rsp_ff[9]  <= 8'(`SKC_SW_OK >> 8);
              rsp_ff[10] <= 8'(`SKC_SW_OK);
              rsp_len_ff <= 4'(`SKC_RSP_BYTES);
            end else begin
              rsp_ff[0]  <= 8'(`SKC_SW_AUTHFAIL >> 8);
              rsp_ff[1]  <= 8'(`SKC_SW_AUTHFAIL);
              rsp_len_ff <= 4'h2;
            end
          end
        end
        ST_REPLY: begin
          if (TX_READY_I) begin
            if (rsp_idx_ff + 4'h1 == rsp_len_ff) begin
              state_ff <= ST_HDR;
            end else begin
              rsp_idx_ff <= rsp_idx_ff + 4'h1;
            end
          end
        end
      endcase
    end
  end

  assign RX_READY_O           = (state_ff == ST_HDR) || (state_ff == ST_DATA);
  assign TX_VALID_O           = (state_ff == ST_REPLY);
  assign TX_DATA_O            = rsp_ff[rsp_idx_ff];
  assign CARD_START_O         = start_ff;
  assign COUPLER_RESP_O       = resp_ff;
  assign COUPLER_RESP_VALID_O = resp_valid_ff;
  assign AUTH_OK_O            = auth_ok_ff;
  assign SIG_O                = sig_ff;
  assign SIG_VALID_O          = sig_valid_ff;

  chk_auth_needs_verdict: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    $rose(auth_ok_ff) |-> $past(CARD_VERDICT_I) && $past(CARD_ACCEPT_I))
    else $error("auth granted without card acceptance");

  chk_auth_result_match: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    state_ff == ST_VERD && CARD_VERDICT_I
      && CARD_RESULT_I != cres_w[31:0] |=> !auth_ok_ff)
    else $error("auth granted on mismatched result");

  chk_resp_before_verd: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CARD_READY_I && state_ff == ST_CARD |=> ##1 resp_valid_ff
      && resp_ff == resp_w[31:0])
    else $error("coupler response not sent after card data");

  chk_sig_one_cycle: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    WR_VALID_I |=> SIG_VALID_O && SIG_O == $past(sig_w[31:0]))
    else $error("signature missing after write data");

  chk_load_deciphers: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    load_go |=> key_ff[$past(hdr_ff[3][4:0])] == $past(plain_w))
    else $error("loaded key not deciphered value");

  chk_bad_key_status: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    state_ff == ST_EXEC && hdr_ff[0] == `SKC_CLA && key_bad
      && (hdr_ff[1] == `SKC_INS_LOAD || hdr_ff[1] == `SKC_INS_KEY)
      |=> rsp_ff[0] == 8'(`SKC_SW_BADKEY >> 8) && rsp_len_ff == 4'h2)
    else $error("out of range key not refused");

  chk_select_derives: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    state_ff == ST_CARD && CARD_READY_I && hdr_ff[1] == `SKC_INS_CARD
      |=> div_ff == $past(div_w) && serial_ff == $past(CARD_SERIAL_I))
    else $error("card select did not diversify");

  chk_load_echo: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    load_go |=> TX_VALID_O && TX_DATA_O == `SKC_INS_LOAD
      && rsp_len_ff == 4'h3)
    else $error("key load reply wrong");

  chk_key_current: assert property (
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    state_ff == ST_EXEC && hdr_ff[0] == `SKC_CLA
      && hdr_ff[1] == `SKC_INS_KEY && !key_bad
      && hdr_ff[4] == `SKC_LEN_KEY |=> cur_ff == $past(hdr_ff[3][4:0]))
    else $error("active key not updated");

endmodule
`default_nettype wire

// *** src/skc_key_mix.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "skc_params.svh"

// keyed mixing step: rotate then xor
module skc_key_mix #(
  parameter int W = 64
) (
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  output logic      [W-1:0] y_o
);

  assign y_o = {a_i[W-1-`SKC_MIX_ROT:0], a_i[W-1:W-`SKC_MIX_ROT]} ^ b_i;

endmodule
`default_nettype wire

// *** tb/skc_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// card side of the authentication exchange
module skc_card_model #(
  parameter logic [63:0] SERIAL = 64'h1122_3344_5566_7788,
  parameter logic [31:0] CHAL   = 32'hA5C3_0F96,
  parameter logic [63:0] CFG    = 64'hC0F1_6000_0000_00FF
) (
  // clock
  input  wire logic        clk_i,
  // from coupler
  input  wire logic        start_i,
  input  wire logic [31:0] resp_i,
  input  wire logic        resp_valid_i,
  // scenario control
  input  wire logic [63:0] key_i,
  input  wire logic        bad_i,
  // to coupler
  output logic             ready_o,
  output logic [63:0]      serial_o,
  output logic [31:0]      chal_o,
  output logic [63:0]      cfg_o,
  output logic             verdict_o,
  output logic             accept_o,
  output logic [31:0]      result_o
);
  logic [63:0] div;
  logic [63:0] tmp;
  logic        acc;
  logic [31:0] res;
  int          n;

  function automatic logic [63:0] mix(input logic [63:0] a,
                                      input logic [63:0] b);
    return {a[58:0], a[63:59]} ^ b;
  endfunction

  // released lines show the inverse of the last value
  assign serial_o = ready_o ? SERIAL : ~SERIAL;
  assign chal_o   = ready_o ? CHAL : ~CHAL;
  assign cfg_o    = ready_o ? CFG : ~CFG;
  assign accept_o = verdict_o ? acc : ~acc;
  assign result_o = verdict_o ? res : ~res;

  initial begin
    ready_o = 1'b0;
    verdict_o = 1'b0;
    acc = 1'b0;
    res = '0;
    forever begin
      @(negedge clk_i);
      if (start_i === 1'b1) begin
        repeat (3) @(negedge clk_i);
        ready_o = 1'b1;
        @(negedge clk_i);
        ready_o = 1'b0;
        n = 0;
        while (resp_valid_i !== 1'b1 && n < 50) begin
          @(negedge clk_i);
          n++;
        end
        div = mix(key_i, SERIAL);
        tmp = mix(div, {CHAL, CHAL});
        acc = (resp_i === tmp[31:0]);
        tmp = mix(div, {~CHAL, CHAL});
        res = tmp[31:0] ^ {31'h0, bad_i};
        repeat (2) @(negedge clk_i);
        verdict_o = 1'b1;
        @(negedge clk_i);
        verdict_o = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// *** tb/skc_cmd_handler_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "skc_params.svh"

module skc_cmd_handler_tb_top;
  localparam logic [63:0] SER = 64'h1122_3344_5566_7788;
  localparam logic [31:0] CHL = 32'hA5C3_0F96;
  localparam logic [63:0] CFG = 64'hC0F1_6000_0000_00FF;
  localparam logic [63:0] D1  = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] D2  = 64'hFEDC_BA98_7654_3210;

  logic        clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        card_start, card_ready, resp_valid, card_verdict;
  logic        card_accept, auth_ok, wr_valid, sig_valid, card_bad;
  logic [7:0]  rx_data, tx_data;
  logic [63:0] card_serial, card_cfg, card_key, k1, k2;
  logic [31:0] card_chal, card_result, resp, wr_data, sig;
  logic [7:0]  rsp [0:15];
  int          err_count, checks, cycles, nrsp;

  skc_cmd_handler i_skc_cmd_handler (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .CARD_START_O(card_start), .CARD_READY_I(card_ready),
    .CARD_SERIAL_I(card_serial), .CARD_CHAL_I(card_chal),
    .CARD_CFG_I(card_cfg), .COUPLER_RESP_O(resp),
    .COUPLER_RESP_VALID_O(resp_valid), .CARD_VERDICT_I(card_verdict),
    .CARD_ACCEPT_I(card_accept), .CARD_RESULT_I(card_result),
    .AUTH_OK_O(auth_ok), .WR_DATA_I(wr_data), .WR_VALID_I(wr_valid),
    .SIG_O(sig), .SIG_VALID_O(sig_valid));

  skc_card_model #(.SERIAL(SER), .CHAL(CHL), .CFG(CFG)) i_skc_card_model (
    .clk_i(clk), .start_i(card_start), .resp_i(resp),
    .resp_valid_i(resp_valid), .key_i(card_key), .bad_i(card_bad),
    .ready_o(card_ready), .serial_o(card_serial), .chal_o(card_chal),
    .cfg_o(card_cfg), .verdict_o(card_verdict), .accept_o(card_accept),
    .result_o(card_result));

  function automatic logic [63:0] mix(input logic [63:0] a,
                                      input logic [63:0] b);
    return {a[58:0], a[63:59]} ^ b;
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one frame out, whole reply back
  task automatic send(input logic [7:0] ins, input logic [7:0] p1,
                      input logic [7:0] p2, input logic [7:0] len,
                      input logic [95:0] d);
    logic [39:0] h;
    int          i;
    int          n;
    h = {`SKC_CLA, ins, p1, p2, len};
    for (i = 0; i < 5 + len; i++) begin
      @(negedge clk);
      rx_data = (i < 5) ? h[39-8*i -: 8] : d[95-8*(i-5) -: 8];
      rx_valid = 1'b1;
      n = 0;
      while (rx_ready !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
    end
    @(negedge clk);
    rx_valid = 1'b0;
    n = 0;
    while (tx_valid !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    nrsp = 0;
    while (tx_valid === 1'b1 && nrsp < 16) begin
      rsp[nrsp] = tx_data;
      nrsp++;
      @(negedge clk);
    end
  endtask

  // nd below zero: error reply without echo
  task automatic reply(input logic [7:0] ins, input int nd,
                       input logic [63:0] d, input logic [15:0] sw);
    int k;
    chk("reply_count", 64'((nd < 0) ? 2 : nd + 3), 64'(nrsp));
    if (nd >= 0) begin
      chk("reply_echo", 64'(ins), 64'(rsp[0]));
    end
    for (k = 0; k < nd; k++) begin
      chk("reply_data", 64'(d[63-8*k -: 8]), 64'(rsp[k+1]));
    end
    chk("reply_sw1", 64'(sw[15:8]), 64'(rsp[nrsp-2]));
    chk("reply_sw2", 64'(sw[7:0]), 64'(rsp[nrsp-1]));
  endtask

  task automatic t_load();
    int n;
    for (n = 1; n <= 16; n++) begin
      send(`SKC_INS_LOAD, 8'h00, 8'(n), `SKC_LEN_LOAD, {D1, 32'h0BAD_F00D});
      reply(`SKC_INS_LOAD, 0, 64'h0, `SKC_SW_OK);
    end
    send(`SKC_INS_LOAD, 8'h00, 8'h02, `SKC_LEN_LOAD, {D2, 32'h1234_5678});
    reply(`SKC_INS_LOAD, 0, 64'h0, `SKC_SW_OK);
  endtask

  task automatic t_badkey();
    send(`SKC_INS_LOAD, 8'h00, 8'h11, `SKC_LEN_LOAD, {D1, 32'h0});
    reply(8'h00, -1, 64'h0, `SKC_SW_BADKEY);
    send(`SKC_INS_KEY, 8'h00, 8'h11, `SKC_LEN_KEY, 96'h0);
    reply(8'h00, -1, 64'h0, `SKC_SW_BADKEY);
  endtask

  task automatic t_card(input logic [7:0] p1, input logic [63:0] key,
                        input logic bad);
    logic [63:0] t;
    card_key = key;
    card_bad = bad;
    t = mix(mix(key, SER), {CHL, CHL});
    send(`SKC_INS_CARD, p1, 8'h00, `SKC_LEN_CARD, 96'h0);
    if (bad == 1'b0) begin
      reply(`SKC_INS_CARD, 8, SER, `SKC_SW_OK);
    end else begin
      reply(8'h00, -1, 64'h0, `SKC_SW_AUTHFAIL);
    end
    chk("coupler_resp", 64'(t[31:0]), 64'(resp));
    chk("auth_ok", 64'(!bad), 64'(auth_ok));
  endtask

  task automatic t_sig(input logic [63:0] key, input logic [31:0] wd);
    logic [63:0] t;
    t = mix(mix(key, SER), {wd, wd});
    @(negedge clk);
    wr_data = wd;
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid = 1'b0;
    chk("sig_valid", 64'h1, 64'(sig_valid));
    chk("sig", 64'(t[31:0]), 64'(sig));
  endtask

  task automatic t_page();
    send(`SKC_INS_KEY, 8'h00, 8'h02, `SKC_LEN_KEY, {SER, 32'h0});
    reply(`SKC_INS_KEY, 0, 64'h0, `SKC_SW_OK);
    chk("auth_ok_derive", 64'h0, 64'(auth_ok));
    card_key = k2;
    card_bad = 1'b0;
    send(`SKC_INS_PAGE, 8'h00, 8'h21, `SKC_LEN_PAGE, 96'h0);
    reply(`SKC_INS_PAGE, 8, CFG, `SKC_SW_OK);
    chk("auth_ok_page", 64'h1, 64'(auth_ok));
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    wr_data = 32'h0;
    wr_valid = 1'b0;
    card_key = 64'h0;
    card_bad = 1'b0;
    k1 = mix(D1, 64'h0);
    k2 = mix(D2, 64'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_load();
    t_badkey();
    send(`SKC_INS_KEY, 8'h00, 8'h01, `SKC_LEN_KEY, 96'h0);
    reply(`SKC_INS_KEY, 0, 64'h0, `SKC_SW_OK);
    t_card(`SKC_P1_DEBIT, k1, 1'b0);
    t_sig(k1, 32'hDEAD_BEEF);
    t_sig(k1, 32'h0000_0001);
    t_card(`SKC_P1_DEBIT, k1, 1'b1);
    t_card(`SKC_P1_CREDIT, k2, 1'b0);
    t_page();
    test_done();
  end
endmodule

`default_nettype wire
